// file: core/fmd_pkg.sv
// Purpose: constants and types for the digital fm discriminator block
// Assumes: 32-bit axi4-lite register access, 100 MHz sys_clk
// Notes:   command word packs first/second/third data bytes in bits 7:0/15:8/23:16
package fmd_pkg;
    localparam logic [7:0]  OFS_COMMAND    = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam int          BYTE1_LSB      = 0;
    localparam int          BYTE2_LSB      = 8;
    localparam int          BYTE3_LSB      = 16;
    localparam int          STAT_D_LSB     = 8;
    localparam int          STAT_M_LSB     = 16;
    localparam logic [1:0]  TYPE_SETUP     = 2'h2;
    localparam logic [1:0]  TYPE_NORMAL    = 2'h1;
    localparam logic [2:0]  PLL_CODE_A     = 3'h4;
    localparam logic [2:0]  PLL_CODE_B     = 3'h3;
    localparam logic [2:0]  PLL_CODE_C     = 3'h5;
    localparam logic [2:0]  PLL_CODE_RESET = 3'h6;
    localparam logic [9:0]  REF_DIV_A      = 10'h064;
    localparam logic [9:0]  REF_DIV_B      = 10'h339;
    localparam logic [9:0]  REF_DIV_C      = 10'h151;
    localparam logic [9:0]  REF_DIV_RESET  = 10'h078;
    localparam logic [9:0]  FB_DIV_A       = 10'h03F;
    localparam logic [9:0]  FB_DIV_B       = 10'h1C0;
    localparam logic [9:0]  FB_DIV_C       = 10'h0B7;
    localparam logic [9:0]  FB_DIV_RESET   = 10'h03F;
    localparam logic [1:0]  D_SEL_00       = 2'h2;
    localparam logic [1:0]  D_SEL_10       = 2'h3;
    localparam logic [1:0]  D_SEL_01       = 2'h3;
    localparam logic [1:0]  D_SEL_11       = 2'h2;
    localparam logic [5:0]  M_SEL_00       = 6'h27;
    localparam logic [5:0]  M_SEL_10       = 6'h28;
    localparam logic [5:0]  M_SEL_01       = 6'h25;
    localparam logic [5:0]  M_SEL_11       = 6'h26;
    localparam logic [1:0]  SEL_RESET      = 2'h0;
    localparam logic        LOCK_RESET     = 1'b0;
    localparam logic        OSC_ON_RESET   = 1'b1;
    localparam logic        DISC_ON_RESET  = 1'b1;

    typedef struct packed {
        logic [1:0] discSel;
        logic       lockFilt;
        logic [2:0] pllCode;
        logic       oscOn;
        logic       discOn;
    } fmd_cfg_t;

    localparam fmd_cfg_t CFG_RESET = '{
        discSel:  SEL_RESET,
        lockFilt: LOCK_RESET,
        pllCode:  PLL_CODE_RESET,
        oscOn:    OSC_ON_RESET,
        discOn:   DISC_ON_RESET
    };
endpackage

// file: core/fmd_discriminator.sv
// Purpose: fm discriminator, afc mix-down sampler and clock pll dividers
// Assumes: crystal, oscillator, bus clock and if input are async pins
// Notes:   all pins pass two flops; rising edges of the synced clock pins pace the logic; the if pin is sampled as a level
`timescale 1ns/1ps
`default_nettype none
module fmd_discriminator
    import fmd_pkg::*;
#(
    parameter int M_MAX = 40
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        crystalClockIn,
    input  wire logic        controllerClockOscillator,
    input  wire logic        serialBusClock,
    input  wire logic        ifLimitedInput,
    output logic             afcMixdownOutput,
    output logic             discOutput,
    output logic             pllRefTick,
    output logic             pllFbTick,
    output logic             oscEnable,
    output logic             lockFilterSel,
    output logic             discActive
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // pin synchronisers, one flop pair per pin
    localparam int NPIN = 4;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_reg;
    logic [NPIN-1:0] pinSync_reg;
    logic [NPIN-1:0] pinPrev_reg;
    logic [NPIN-1:0] pinRise;

    assign pinRaw = {ifLimitedInput, serialBusClock,
                     controllerClockOscillator, crystalClockIn};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pinMeta_reg[gi] <= 1'b0;
                    pinSync_reg[gi] <= 1'b0;
                    pinPrev_reg[gi] <= 1'b0;
                end else begin
                    pinMeta_reg[gi] <= pinRaw[gi];
                    pinSync_reg[gi] <= pinMeta_reg[gi];
                    pinPrev_reg[gi] <= pinSync_reg[gi];
                end
            end
            assign pinRise[gi] = pinSync_reg[gi] & ~pinPrev_reg[gi];
        end
    endgenerate

    wire xtalRise = pinRise[0];
    wire oscRise  = pinRise[1];
    wire busRise  = pinRise[2];
    // both paths read the same synced if sample
    wire ifSync   = pinSync_reg[3];

    // configuration
    fmd_cfg_t   cfg_reg;
    fmd_cfg_t   cfg_next;
    logic [31:0] command_reg;
    logic        cfgSeen_reg;

    // axi4-lite write side
    logic        awReady_reg;
    logic        wReady_reg;
    logic        bValid_reg;
    logic [1:0]  bResp_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;

    wire awFire  = s_axi_awvalid & awReady_reg;
    wire wFire   = s_axi_wvalid & wReady_reg;
    wire doWrite = ~awReady_reg & ~wReady_reg & ~bValid_reg;
    wire wrCmd   = doWrite & (awAddr_reg == OFS_COMMAND);

    logic [31:0] cmdMerged;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign cmdMerged[gi*8 +: 8] = wStrb_reg[gi] ? wData_reg[gi*8 +: 8]
                                                        : command_reg[gi*8 +: 8];
        end
    endgenerate

    wire [7:0] byte1 = cmdMerged[BYTE1_LSB +: 8];
    wire [7:0] byte2 = cmdMerged[BYTE2_LSB +: 8];
    wire [7:0] byte3 = cmdMerged[BYTE3_LSB +: 8];

    wire isSetup   = wrCmd & (byte2[7:6] == TYPE_SETUP) & (byte3[1:0] == 2'h0);
    wire isNormal  = wrCmd & (byte2[7:6] == TYPE_NORMAL);
    wire setupDisc = isSetup & byte3[5];

    always_comb begin
        cfg_next = cfg_reg;
        if (setupDisc) begin
            cfg_next.discSel  = byte1[7:6];
            cfg_next.lockFilt = byte1[5];
            cfg_next.pllCode  = byte1[2:0];
        end
        if (isSetup) begin
            cfg_next.oscOn = byte2[0];
        end
        if (isNormal) begin
            cfg_next.discOn = byte2[5];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg     <= CFG_RESET;
            command_reg <= 32'h0000_0000;
            cfgSeen_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            if (wrCmd) begin
                command_reg <= cmdMerged;
            end
            if (setupDisc) begin
                cfgSeen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awReady_reg <= 1'b1;
            wReady_reg  <= 1'b1;
            bValid_reg  <= 1'b0;
            bResp_reg   <= RESP_OKAY;
            awAddr_reg  <= 8'h00;
            wData_reg   <= 32'h0000_0000;
            wStrb_reg   <= 4'h0;
        end else begin
            if (awFire) begin
                awAddr_reg  <= s_axi_awaddr;
                awReady_reg <= 1'b0;
            end
            if (wFire) begin
                wData_reg  <= s_axi_wdata;
                wStrb_reg  <= s_axi_wstrb;
                wReady_reg <= 1'b0;
            end
            if (doWrite) begin
                bValid_reg <= 1'b1;
                // status is read-only, so a write there is an error too
                bResp_reg  <= (wrCmd) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bValid_reg & s_axi_bready) begin
                bValid_reg  <= 1'b0;
                awReady_reg <= 1'b1;
                wReady_reg  <= 1'b1;
            end
        end
    end

    // divider and delay selection
    logic [1:0] dSel;
    logic [5:0] mSel;
    logic [9:0] refDiv;
    logic [9:0] fbDiv;

    assign dSel = (cfg_reg.discSel == 2'h0) ? D_SEL_00 :
                  (cfg_reg.discSel == 2'h2) ? D_SEL_10 :
                  (cfg_reg.discSel == 2'h1) ? D_SEL_01 :
                                              D_SEL_11;
    assign mSel = (cfg_reg.discSel == 2'h0) ? M_SEL_00 :
                  (cfg_reg.discSel == 2'h2) ? M_SEL_10 :
                  (cfg_reg.discSel == 2'h1) ? M_SEL_01 :
                                              M_SEL_11;
    // unlisted codes fall back to the slowest-safe power-up pair
    assign refDiv = (cfg_reg.pllCode == PLL_CODE_A) ? REF_DIV_A :
                    (cfg_reg.pllCode == PLL_CODE_B) ? REF_DIV_B :
                    (cfg_reg.pllCode == PLL_CODE_C) ? REF_DIV_C :
                                                      REF_DIV_RESET;
    assign fbDiv  = (cfg_reg.pllCode == PLL_CODE_A) ? FB_DIV_A :
                    (cfg_reg.pllCode == PLL_CODE_B) ? FB_DIV_B :
                    (cfg_reg.pllCode == PLL_CODE_C) ? FB_DIV_C :
                                                      FB_DIV_RESET;

    // read side
    logic        arReady_reg;
    logic        rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0]  rResp_reg;
    logic [31:0] statusWord;

    assign statusWord = {10'h000, mSel, 6'h00, dSel, cfg_reg};
    wire   arFire = s_axi_arvalid & arReady_reg;
    wire   rdCmd  = s_axi_araddr == OFS_COMMAND;
    wire   rdStat = s_axi_araddr == OFS_STATUS;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            arReady_reg <= 1'b1;
            rValid_reg  <= 1'b0;
            rData_reg   <= 32'h0000_0000;
            rResp_reg   <= RESP_OKAY;
        end else begin
            if (arFire) begin
                arReady_reg <= 1'b0;
                rValid_reg  <= 1'b1;
                rData_reg   <= rdCmd ? command_reg : rdStat ? statusWord : 32'h0000_0000;
                rResp_reg   <= (rdCmd | rdStat) ? RESP_OKAY : RESP_SLVERR;
            end
            if (rValid_reg & s_axi_rready) begin
                rValid_reg  <= 1'b0;
                arReady_reg <= 1'b1;
            end
        end
    end

    // clock pll dividers
    logic [9:0] refCnt_reg;
    logic [9:0] fbCnt_reg;
    logic       refTick_reg;
    logic       fbTick_reg;

    wire refWrap = xtalRise & (refCnt_reg >= refDiv - 10'h001);
    wire fbWrap  = oscRise & cfg_reg.oscOn & (fbCnt_reg >= fbDiv - 10'h001);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            refCnt_reg  <= 10'h000;
            fbCnt_reg   <= 10'h000;
            refTick_reg <= 1'b0;
            fbTick_reg  <= 1'b0;
        end else begin
            refTick_reg <= refWrap;
            fbTick_reg  <= fbWrap;
            if (refWrap) begin
                refCnt_reg <= 10'h000;
            end else if (xtalRise) begin
                refCnt_reg <= refCnt_reg + 10'h001;
            end
            // oscillator off: feedback count parks at zero
            if (fbWrap | ~cfg_reg.oscOn) begin
                fbCnt_reg <= 10'h000;
            end else if (oscRise) begin
                fbCnt_reg <= fbCnt_reg + 10'h001;
            end
        end
    end

    // afc mix-down sampler at half the bus clock
    logic       busPhase_reg;
    logic       afc_reg;
    logic [1:0] busSkip_reg;
    wire        afcSample = busRise & busPhase_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busPhase_reg <= 1'b0;
            afc_reg      <= 1'b0;
            busSkip_reg  <= 2'h0;
        end else begin
            if (busRise) begin
                busPhase_reg <= ~busPhase_reg;
                // unsampled bus rises since the last sample, for the rate check
                busSkip_reg  <= afcSample ? 2'h0 : busSkip_reg + 2'h1;
            end
            if (afcSample) begin
                afc_reg <= ifSync;
            end
        end
    end

    // discriminator: sample tick every D crystal edges
    logic [1:0]       dCnt_reg;
    logic [M_MAX-1:0] delay_reg;
    logic             disc_reg;
    wire  discTick = xtalRise & (dCnt_reg >= dSel - 2'h1);
    wire  [5:0] tapIdx = mSel - 6'h01;
    wire  tap = delay_reg[tapIdx];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dCnt_reg  <= 2'h0;
            delay_reg <= '0;
            disc_reg  <= 1'b0;
        end else begin
            // crystal-paced so every delay spans the same time
            // a new D restarts the count so it never overruns the divider
            if (discTick | setupDisc) begin
                dCnt_reg <= 2'h0;
            end else if (xtalRise) begin
                dCnt_reg <= dCnt_reg + 2'h1;
            end
            if (discTick) begin
                delay_reg <= {delay_reg[M_MAX-2:0], ifSync};
            end
            if (~cfg_reg.discOn) begin
                disc_reg <= 1'b0;
            end else if (discTick) begin
                disc_reg <= ifSync ^ tap;
            end
        end
    end

    assign s_axi_awready    = awReady_reg;
    assign s_axi_wready     = wReady_reg;
    assign s_axi_bvalid     = bValid_reg;
    assign s_axi_bresp      = bResp_reg;
    assign s_axi_arready    = arReady_reg;
    assign s_axi_rvalid     = rValid_reg;
    assign s_axi_rdata      = rData_reg;
    assign s_axi_rresp      = rResp_reg;
    assign afcMixdownOutput = afc_reg;
    assign discOutput       = disc_reg;
    assign pllRefTick       = refTick_reg;
    assign pllFbTick        = fbTick_reg;
    assign oscEnable        = cfg_reg.oscOn;
    assign lockFilterSel    = cfg_reg.lockFilt;
    assign discActive       = cfg_reg.discOn;

    a_pll_code_a:
        assert property (cfg_reg.pllCode == PLL_CODE_A |-> refDiv == 10'd100 && fbDiv == 10'd63)
        else $error("code 100 dividers wrong");
    a_pll_code_b:
        assert property (cfg_reg.pllCode == PLL_CODE_B |-> refDiv == 10'd825 && fbDiv == 10'd448)
        else $error("code 011 dividers wrong");
    a_pll_code_c:
        assert property (cfg_reg.pllCode == PLL_CODE_C |-> refDiv == 10'd337 && fbDiv == 10'd183)
        else $error("code 101 dividers wrong");
    a_pll_powerup_code:
        assert property (!cfgSeen_reg |-> cfg_reg.pllCode == 3'h6 && refDiv == 10'd120)
        else $error("power-up pll code wrong");
    a_setup_loads_sel:
        assert property (setupDisc |=> cfg_reg.discSel == $past(byte1[7:6])
                         && cfg_reg.pllCode == $past(byte1[2:0]))
        else $error("setup did not load select and code");
    a_normal_disc_power:
        assert property (isNormal |=> cfg_reg.discOn == $past(byte2[5]) ##1
                         (cfg_reg.discOn || !disc_reg))
        else $error("discriminator power not applied");
    a_osc_switch:
        assert property (isSetup |=> oscEnable == $past(byte2[0]))
        else $error("oscillator switch not applied");
    a_dm_select_map:
        assert property ((cfg_reg.discSel == 2'h0 |-> dSel == 2'd2 && mSel == 6'd39)
                         and (cfg_reg.discSel == 2'h2 |-> dSel == 2'd3 && mSel == 6'd40)
                         and (cfg_reg.discSel == 2'h1 |-> dSel == 2'd3 && mSel == 6'd37)
                         and (cfg_reg.discSel == 2'h3 |-> dSel == 2'd2 && mSel == 6'd38))
        else $error("d and m selection wrong");
    a_afc_half_rate:
        assert property ((busRise |-> busSkip_reg <= 2'h1
                          && (afcSample == (busSkip_reg == 2'h1)))
                         and (afcSample |=> afcMixdownOutput == $past(ifSync)))
        else $error("afc sampler not at half bus rate");
    a_disc_xor_out:
        assert property (discTick && cfg_reg.discOn |=>
                         discOutput == ($past(ifSync) ^ $past(tap)))
        else $error("discriminator xor wrong");
    a_disc_tick_pace:
        assert property (discTick |-> xtalRise && dCnt_reg == dSel - 2'h1)
        else $error("sample tick not every D crystal edges");

endmodule // fmd_discriminator
`default_nettype wire

// file: test/fmd_pins_model.sv
// Purpose: pin-level model of crystal, controller oscillator, bus clock and limiter
// Assumes: pin edges never land on a rising sys_clk edge (half periods end in 0 or 2 ns)
// Notes:   limiter output runs free or holds a level chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module fmd_pins_model (
    input  wire logic ifRun,
    input  wire logic ifLevel,
    output logic      crystalClockIn,
    output logic      controllerClockOscillator,
    output logic      serialBusClock,
    output logic      ifLimitedInput
);
    logic ifPhase;

    initial begin
        crystalClockIn = 1'b0;
        controllerClockOscillator = 1'b0;
        serialBusClock = 1'b0;
        ifPhase = 1'b0;
    end
    always #30 crystalClockIn = ~crystalClockIn;
    always #20 controllerClockOscillator = ~controllerClockOscillator;
    always #52 serialBusClock = ~serialBusClock;
    // off the crystal grid, so the sampling never locks to it
    always #170 ifPhase = ~ifPhase;
    assign ifLimitedInput = ifRun ? ifPhase : ifLevel;
endmodule // fmd_pins_model
`default_nettype wire

// file: test/digital_fm_discriminator_bench.sv
// Purpose: self-checking bench for the fm discriminator block
// Assumes: crystal period 6 sys_clk, oscillator period 4 sys_clk
// Notes:   divider ratios are measured as sys_clk counts between ticks
`timescale 1ns/1ps
`default_nettype none
module digital_fm_discriminator_bench
    import fmd_pkg::*;
;
    localparam int XTAL_CYC = 6;
    localparam int OSC_CYC  = 4;
    // pairs chosen so D 3 never meets a 450 kHz setting on the 14.85 crystal codes
    localparam logic [2:0] CODES [4] = '{3'h4, 3'h6, 3'h3, 3'h5};
    localparam int         REFS  [4] = '{100, 120, 825, 337};
    localparam int         FBS   [4] = '{63, 63, 448, 183};
    localparam logic [1:0] DS    [4] = '{2'h2, 2'h3, 2'h3, 2'h2};
    localparam logic [5:0] MS    [4] = '{6'h27, 6'h25, 6'h28, 6'h26};
    logic        sys_clk;
    logic        reset_n;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid, s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid, s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid, s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid, s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid, s_axi_rready;
    logic        crystalClockIn, controllerClockOscillator, serialBusClock;
    logic        ifLimitedInput, ifRun, ifLevel;
    logic        afcMixdownOutput, discOutput, pllRefTick, pllFbTick;
    logic        oscEnable, lockFilterSel, discActive;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          cycleCount = 0;

    fmd_discriminator dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .crystalClockIn(crystalClockIn), .controllerClockOscillator(controllerClockOscillator),
        .serialBusClock(serialBusClock), .ifLimitedInput(ifLimitedInput),
        .afcMixdownOutput(afcMixdownOutput), .discOutput(discOutput),
        .pllRefTick(pllRefTick), .pllFbTick(pllFbTick), .oscEnable(oscEnable),
        .lockFilterSel(lockFilterSel), .discActive(discActive));
    fmd_pins_model pins_u (.ifRun(ifRun), .ifLevel(ifLevel), .crystalClockIn(crystalClockIn),
        .controllerClockOscillator(controllerClockOscillator),
        .serialBusClock(serialBusClock), .ifLimitedInput(ifLimitedInput));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ceiling well above the ~50k cycles the sequence needs
    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount == 90000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end while (!done);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic [31:0] setup_word(logic [1:0] sel, logic lk, logic [2:0] code);
        return {8'h00, 8'h20, 8'h81, sel, lk, 2'h0, code};
    endfunction

    function automatic logic [31:0] stat(logic [1:0] sel, logic lk, logic [2:0] code, logic osc,
                                         logic dsc, logic [1:0] d, logic [5:0] m);
        return {10'h000, m, 6'h00, d, sel, lk, code, osc, dsc};
    endfunction

    task automatic wait_tick(input logic fb);
        do @(posedge sys_clk); while ((fb ? pllFbTick : pllRefTick) !== 1'b1);
    endtask

    // first interval after a change may be partial, so skip it
    task automatic measure(input logic fb, input int exp);
        int n;
        n = 0;
        repeat (2) wait_tick(fb);
        do begin
            @(posedge sys_clk);
            n++;
        end while ((fb ? pllFbTick : pllRefTick) !== 1'b1);
        check(fb ? "fb period" : "ref period", exp, n);
    endtask

    // one input step gives one pulse lasting the delay up to the M tap
    task automatic disc_pulse(input int w);
        int n;
        n = 0;
        repeat (800) @(posedge sys_clk);
        ifLevel <= ~ifLevel;
        while (discOutput !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (discOutput === 1'b1) begin
            @(posedge sys_clk);
            n++;
        end
        check("disc pulse", w, n);
        check("afc level", ifLevel, afcMixdownOutput);
    endtask

    task automatic t_reset();
        logic [1:0]  r;
        logic [31:0] v;
        axi_read(OFS_STATUS, v, r);
        check("reset status", stat(2'h0, 1'b0, 3'h6, 1'b1, 1'b1, 2'h2, 6'h27), v);
        measure(1'b0, 120 * XTAL_CYC);
        measure(1'b1, 63 * OSC_CYC);
    endtask

    task automatic t_config();
        logic [1:0]  r;
        logic [31:0] v;
        for (int i = 0; i < 4; i++) begin
            axi_write(OFS_COMMAND, setup_word(i[1:0], i[0], CODES[i]), 4'hF, r);
            check("setup resp", RESP_OKAY, r);
            axi_read(OFS_STATUS, v, r);
            check("status", stat(i[1:0], i[0], CODES[i], 1'b1, 1'b1, DS[i], MS[i]), v);
            check("lock pin", i[0], lockFilterSel);
            disc_pulse(DS[i] * MS[i] * XTAL_CYC);
            measure(1'b0, REFS[i] * XTAL_CYC);
            measure(1'b1, FBS[i] * OSC_CYC);
        end
    endtask

    task automatic t_power();
        logic [1:0]  r;
        logic [31:0] v;
        int          hi;
        hi = 0;
        ifRun <= 1'b1;
        axi_write(OFS_COMMAND, 32'h00004000, 4'h2, r);
        axi_read(OFS_COMMAND, v, r);
        check("merged word", 32'h002040E5, v);
        check("disc off", 1'b0, discActive);
        repeat (2000) begin
            @(posedge sys_clk);
            if (discOutput !== 1'b0) hi++;
        end
        check("disc off output", 0, hi);
        axi_write(OFS_COMMAND, 32'h00006000, 4'h2, r);
        axi_read(OFS_STATUS, v, r);
        check("disc on status", stat(2'h3, 1'b1, 3'h5, 1'b1, 1'b1, 2'h2, 6'h26), v);
        check("disc on", 1'b1, discActive);
        repeat (2000) begin
            @(posedge sys_clk);
            if (discOutput === 1'b1) hi++;
        end
        check("disc on output", 1'b1, hi > 0);
    endtask

    task automatic t_osc();
        logic [1:0]  r;
        logic [31:0] v;
        int          n;
        n = 0;
        axi_write(OFS_COMMAND, 32'h00008000, 4'hF, r);
        axi_read(OFS_STATUS, v, r);
        check("osc off status", stat(2'h3, 1'b1, 3'h5, 1'b0, 1'b1, 2'h2, 6'h26), v);
        check("osc pin", 1'b0, oscEnable);
        repeat (600) begin
            @(posedge sys_clk);
            if (pllFbTick !== 1'b0) n++;
        end
        check("fb ticks off", 0, n);
        axi_write(OFS_COMMAND, 32'h00008100, 4'hF, r);
        measure(1'b1, 183 * OSC_CYC);
        axi_write(OFS_STATUS, 32'h00000000, 4'hF, r);
        check("ro write resp", RESP_SLVERR, r);
        axi_read(8'h08, v, r);
        check("unmapped resp", RESP_SLVERR, r);
        check("unmapped data", 32'h00000000, v);
        // byte3 low bits not 00: not a setup, the configuration does not change
        axi_write(OFS_COMMAND, setup_word(2'h0, 1'b0, 3'h7) | 32'h00010000, 4'hF, r);
        axi_read(OFS_STATUS, v, r);
        check("ignored setup", stat(2'h3, 1'b1, 3'h5, 1'b1, 1'b1, 2'h2, 6'h26), v);
        axi_write(OFS_COMMAND, setup_word(2'h0, 1'b0, 3'h7), 4'hF, r);
        measure(1'b0, 120 * XTAL_CYC);
    endtask

    initial begin
        reset_n = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        ifRun = 1'b0;
        ifLevel = 1'b0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_config();
        t_power();
        t_osc();
        complete_run();
    end
endmodule // digital_fm_discriminator_bench
`default_nettype wire
